/* lgs_defines.vh */
// register map, reset values and timing counts of the glyph scan block
`ifndef LGS_DEFINES_VH
`define LGS_DEFINES_VH
// --------------------------------------------------------------
// register offsets
// --------------------------------------------------------------
`define LGS_ADDR_SCAN_SPAN 8'h03
`define LGS_ADDR_GLYPH_PORT 8'h05
`define LGS_ADDR_DISP_TEST 8'h07
`define LGS_ADDR_CTRL 8'h0E
`define LGS_ADDR_DIGIT0 8'h20
`define LGS_ADDR_DIGIT3 8'h23
// --------------------------------------------------------------
// field positions
// --------------------------------------------------------------
`define LGS_SPAN_BIT 0
`define LGS_TEST_BIT 0
`define LGS_CTRL_RUN_BIT 0
`define LGS_CTRL_SLOW_BIT 1
`define LGS_CTRL_PHASE_BIT 7
`define LGS_PTR_LOAD_BIT 7
// --------------------------------------------------------------
// glyph pointer range
// --------------------------------------------------------------
`define LGS_PTR_FIRST 8'h80
`define LGS_PTR_LAST 8'hF7
`define LGS_PTR_BAD 8'hF8
`define LGS_GLYPH_COLS 5
`define LGS_USER_GLYPHS 24
// --------------------------------------------------------------
// reset values
// --------------------------------------------------------------
`define LGS_RST_SPAN 8'h00
`define LGS_RST_TEST 8'h00
`define LGS_RST_CTRL 8'h00
`define LGS_RST_DIGIT 8'h20
// --------------------------------------------------------------
// timing, counted in multiplex clock ticks
// --------------------------------------------------------------
`define LGS_OSC_MHZ 4
`define LGS_ROW_TIME_US 100
`define LGS_ROW_TICKS (`LGS_ROW_TIME_US * `LGS_OSC_MHZ)
`define LGS_DUTY_STEPS 16
`define LGS_DUTY_NORMAL 15
`define LGS_DUTY_TEST 7
`define LGS_BLINK_FAST_HZ 1
`define LGS_BLINK_HALF_FAST (`LGS_OSC_MHZ * 1000000 / (2 * `LGS_BLINK_FAST_HZ))
`define LGS_TEST_SLOTS 8
`endif

/* lgs_top.v */
// glyph memory, digit scan span, display test and blink timing of the led driver
`timescale 1ns/10ps
// Notes on behaviour
// - host writes glyph base pointer first; device loads pointer with it.
// - glyph data byte stored at pointer address, then pointer advances by one.
// - entries hold seven bits; bit 7 clear marks a data write.
// - one glyph is five entries; six writes load it; pointer ends at next base.
// - span bit 0 clear scans digits 0 and 1 only, other bits ignored.
// - span bit 0 set scans all four digits, other bits ignored.
// - display test register selects normal operation or test.
// - test lights every led, stored registers untouched, display returns after.
// - test alternates both digit pairs over eight slots at fixed seven sixteenths duty.
// - blink timing divided from multiplex clock gives 1 Hz or 0.5 Hz.
// - glyph port write with bit 7 set loads the pointer.
// - access at last pointer value wraps pointer to first value.
// - pointer load in invalid range sets pointer to first value.
// - digits 0 and 1 share one slot, digits 2 and 3 the next.
`include "lgs_defines.vh"
module lgs_top #(
  parameter ROW_TICKS = `LGS_ROW_TICKS,
  parameter BLINK_HALF = `LGS_BLINK_HALF_FAST
) (
  // clock and reset
  input wire sys_clk_in,
  input wire srst_in,
  // register port
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  // multiplex clock pin
  input wire multiplex_clock_pin_in,
  // led drive
  output reg [1:0] pair_sel_out,
  output reg [6:0] row_out,
  output reg [9:0] col_out,
  output reg blink_phase_out
);
  // --------------------------------------------------------------
  // constants
  // --------------------------------------------------------------
  localparam MEM_DEPTH = `LGS_USER_GLYPHS * `LGS_GLYPH_COLS;
  localparam PHASE_TICKS = ROW_TICKS / `LGS_DUTY_STEPS;
  localparam [7:0] PTR_FIRST = `LGS_PTR_FIRST;
  localparam [7:0] PTR_LAST = `LGS_PTR_LAST;
  localparam [7:0] PTR_BAD = `LGS_PTR_BAD;
  localparam [4:0] NUM_GLYPHS = `LGS_USER_GLYPHS;
  localparam [3:0] DUTY_NORMAL = `LGS_DUTY_NORMAL;
  localparam [3:0] DUTY_TEST = `LGS_DUTY_TEST;
  localparam [2:0] LAST_ROW = 3'h6;
  // scan states, one-hot
  localparam [2:0] ST_OFF = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_TEST = 3'b100;

  // --------------------------------------------------------------
  // functions
  // --------------------------------------------------------------
  // pointer after a data access, wrapping at the top
  function [7:0] ptr_step;
    input [7:0] p;
    begin
      if (p == PTR_LAST) begin
        ptr_step = PTR_FIRST;
      end else begin
        ptr_step = p + 8'h01;
      end
    end
  endfunction

  // pointer after a load, refusing the invalid range
  function [7:0] ptr_load;
    input [7:0] v;
    begin
      if (v >= PTR_BAD) begin
        ptr_load = PTR_FIRST;
      end else begin
        ptr_load = v;
      end
    end
  endfunction

  // column pattern of a digit: user glyph code selects five entries
  function [6:0] glyph_col;
    input [7:0] code;
    input integer col;
    input [34:0] flat;
    begin
      if (code < {3'h0, NUM_GLYPHS}) begin
        glyph_col = flat[col*7 +: 7];
      end else begin
        glyph_col = 7'h00;
      end
    end
  endfunction

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  reg [7:0] span_r;
  reg [7:0] test_r;
  reg [7:0] ctrl_r;
  reg [7:0] ptr_r;
  reg [7:0] digit_r [0:3];
  reg [6:0] glyph_mem [0:MEM_DEPTH-1];
  reg [7:0] rdata_nxt;
  wire [6:0] ptr_idx;
  wire glyph_wr;
  wire glyph_rd;
  wire [7:0] ptr_nxt;
  integer i;

  assign ptr_idx = ptr_r[6:0];
  assign glyph_wr = reg_wr_in && (reg_addr_in == `LGS_ADDR_GLYPH_PORT);
  assign glyph_rd = reg_rd_in && (reg_addr_in == `LGS_ADDR_GLYPH_PORT);

  // pointer update: load, data step or hold
  assign ptr_nxt = (glyph_wr && reg_wdata_in[`LGS_PTR_LOAD_BIT]) ?
                   ptr_load(reg_wdata_in) :
                   (glyph_wr || glyph_rd) ? ptr_step(ptr_r) : ptr_r;

  // register writes; test mode changes none of the stored values
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      span_r <= `LGS_RST_SPAN;
      test_r <= `LGS_RST_TEST;
      ctrl_r <= `LGS_RST_CTRL;
      ptr_r <= PTR_FIRST;
      for (i = 0; i < 4; i = i + 1) begin
        digit_r[i] <= `LGS_RST_DIGIT;
      end
    end else begin
      ptr_r <= ptr_nxt;
      if (reg_wr_in) begin
        case (reg_addr_in)
          `LGS_ADDR_SCAN_SPAN: span_r <= reg_wdata_in;
          `LGS_ADDR_DISP_TEST: test_r <= reg_wdata_in;
          `LGS_ADDR_CTRL: ctrl_r <= reg_wdata_in;
          default: begin
            if (reg_addr_in >= `LGS_ADDR_DIGIT0 && reg_addr_in <= `LGS_ADDR_DIGIT3) begin
              digit_r[reg_addr_in[1:0]] <= reg_wdata_in;
            end
          end
        endcase
      end
    end
  end

  // glyph memory store, no reset needed
  always @(posedge sys_clk_in) begin
    if (glyph_wr && !reg_wdata_in[`LGS_PTR_LOAD_BIT]) begin
      glyph_mem[ptr_idx] <= reg_wdata_in[6:0];
    end
  end

  // read data mux
  always @* begin
    rdata_nxt = 8'h00;
    case (reg_addr_in)
      `LGS_ADDR_SCAN_SPAN: rdata_nxt = span_r;
      `LGS_ADDR_GLYPH_PORT: rdata_nxt = {1'b0, glyph_mem[ptr_idx]};
      `LGS_ADDR_DISP_TEST: rdata_nxt = test_r;
      `LGS_ADDR_CTRL: rdata_nxt = {blink_phase_out, ctrl_r[6:0]};
      default: begin
        if (reg_addr_in >= `LGS_ADDR_DIGIT0 && reg_addr_in <= `LGS_ADDR_DIGIT3) begin
          rdata_nxt = digit_r[reg_addr_in[1:0]];
        end
      end
    endcase
  end

  // read data stands one cycle after the strobe
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_nxt;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // --------------------------------------------------------------
  // multiplex clock pin synchroniser
  // --------------------------------------------------------------
  reg [2:0] osc_sync_r;
  reg osc_lvl_r;
  wire osc_tick;

  // three stages; level accepted once stages two and three agree
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      osc_sync_r <= 3'h0;
      osc_lvl_r <= 1'b0;
    end else begin
      osc_sync_r <= {osc_sync_r[1:0], multiplex_clock_pin_in};
      if (osc_sync_r[1] == osc_sync_r[2]) begin
        osc_lvl_r <= osc_sync_r[2];
      end
    end
  end

  assign osc_tick = osc_sync_r[1] && osc_sync_r[2] && !osc_lvl_r;

  // --------------------------------------------------------------
  // blink divider
  // --------------------------------------------------------------
  reg [23:0] blink_cnt_r;
  wire [23:0] blink_half;

  // slow rate doubles the half period
  assign blink_half = ctrl_r[`LGS_CTRL_SLOW_BIT] ?
                      BLINK_HALF[22:0] * 24'd2 : BLINK_HALF[23:0];

  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      blink_cnt_r <= 24'h000000;
      blink_phase_out <= 1'b1;
    end else if (osc_tick) begin
      if (blink_cnt_r >= blink_half - 24'd1) begin
        blink_cnt_r <= 24'h000000;
        blink_phase_out <= !blink_phase_out;
      end else begin
        blink_cnt_r <= blink_cnt_r + 24'd1;
      end
    end
  end

  // --------------------------------------------------------------
  // scan sequencer
  // --------------------------------------------------------------
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [15:0] tick_r;
  reg [3:0] phase_r;
  reg [2:0] row_r;
  reg [2:0] slot_r;
  wire test_on;
  wire four_dig;
  wire phase_end;
  wire row_end;

  assign test_on = test_r[`LGS_TEST_BIT];
  assign four_dig = span_r[`LGS_SPAN_BIT];
  assign phase_end = osc_tick && (tick_r == PHASE_TICKS[15:0] - 16'd1);
  assign row_end = phase_end && (phase_r == 4'hF);

  // test overrides run and off states
  always @* begin
    case (state_r)
      ST_OFF: state_nxt = test_on ? ST_TEST : (ctrl_r[0] ? ST_RUN : ST_OFF);
      ST_RUN: state_nxt = test_on ? ST_TEST : (ctrl_r[0] ? ST_RUN : ST_OFF);
      ST_TEST: state_nxt = test_on ? ST_TEST : (ctrl_r[0] ? ST_RUN : ST_OFF);
      default: state_nxt = ST_OFF;
    endcase
  end

  // tick, duty phase, slot and row counters
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      state_r <= ST_OFF;
      tick_r <= 16'h0000;
      phase_r <= 4'h0;
      row_r <= 3'h0;
      slot_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      if (osc_tick) begin
        tick_r <= phase_end ? 16'h0000 : tick_r + 16'd1;
      end
      if (phase_end) begin
        phase_r <= phase_r + 4'h1;
      end
      if (row_end) begin
        if (state_r == ST_TEST) begin
          slot_r <= slot_r + 3'h1;
        end else if (four_dig && !slot_r[0]) begin
          slot_r <= 3'h1;
        end else begin
          slot_r <= 3'h0;
          row_r <= (row_r == LAST_ROW) ? 3'h0 : row_r + 3'h1;
        end
      end
    end
  end

  // --------------------------------------------------------------
  // column patterns, read straight from glyph memory
  // --------------------------------------------------------------
  // five entries of 7 bits per digit, digits side by side
  wire [139:0] glyph_flat;
  // even digit columns low, odd digit columns high, pair 0 then pair 1
  wire [19:0] pair_cols;
  genvar d;
  genvar c;
  generate
    for (d = 0; d < 4; d = d + 1) begin : g_dig
      wire [6:0] base;
      assign base = digit_r[d][6:0] * 7'd5;
      for (c = 0; c < 5; c = c + 1) begin : g_col
        assign glyph_flat[d*35 + c*7 +: 7] =
          (base < MEM_DEPTH) ? glyph_mem[base + c] : 7'h00;
      end
    end
    for (d = 0; d < 2; d = d + 1) begin : g_pair
      for (c = 0; c < 5; c = c + 1) begin : g_bit
        wire [6:0] even_col;
        wire [6:0] odd_col;
        assign even_col = glyph_col(digit_r[2*d], c, glyph_flat[2*d*35 +: 35]);
        assign odd_col = glyph_col(digit_r[2*d+1], c, glyph_flat[(2*d+1)*35 +: 35]);
        assign pair_cols[d*10 + c] = even_col[row_r];
        assign pair_cols[d*10 + c + 5] = odd_col[row_r];
      end
    end
  endgenerate

  // --------------------------------------------------------------
  // led drive
  // --------------------------------------------------------------
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      pair_sel_out <= 2'b00;
      row_out <= 7'h00;
      col_out <= 10'h000;
    end else begin
      case (state_r)
        ST_TEST: begin
          // every led lit, fixed duty regardless of stored settings
          pair_sel_out <= slot_r[0] ? 2'b10 : 2'b01;
          row_out <= (phase_r < DUTY_TEST) ? 7'h7F : 7'h00;
          col_out <= 10'h3FF;
        end
        ST_RUN: begin
          // digits 0,1 then 2,3 in alternate slots
          pair_sel_out <= slot_r[0] ? 2'b10 : 2'b01;
          row_out <= (phase_r < DUTY_NORMAL) ? (7'h01 << row_r) : 7'h00;
          col_out <= slot_r[0] ? pair_cols[19:10] : pair_cols[9:0];
        end
        default: begin
          pair_sel_out <= 2'b00;
          row_out <= 7'h00;
          col_out <= 10'h000;
        end
      endcase
    end
  end
endmodule

/* lgs_osc_model.sv */
// external multiplex oscillator model driving the scan timing pin
`timescale 1ns/10ps
module lgs_osc_model #(
  parameter real HALF_NS = 12.3,
  parameter real PHASE_NS = 0.01
) (
  // oscillator output
  output logic multiplex_clock_pin_out
);
  // free-running source, phase unrelated to the system clock
  // small start offset keeps every pin edge off the system clock edges
  initial begin
    multiplex_clock_pin_out = 1'b0;
    #(PHASE_NS);
    forever #(HALF_NS) multiplex_clock_pin_out = ~multiplex_clock_pin_out;
  end
endmodule

/* lgs_top_chk.sv */
// port checker for the glyph scan block
`timescale 1ns/10ps
module lgs_top_chk (
  // clock, reset and register port
  input wire sys_clk_in,
  input wire srst_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  // led drive
  input wire [1:0] pair_sel_out,
  input wire [6:0] row_out,
  input wire [9:0] col_out,
  input wire blink_phase_out
);
  reg span_r;
  reg test_r;
  reg run_r;
  reg [7:0] stay_r;
  wire settled = (stay_r == 8'hFF);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  // shadow of mode bits, and cycles since the last mode change
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      span_r <= 1'b0;
      test_r <= 1'b0;
      run_r <= 1'b0;
      stay_r <= 8'h00;
    end else if (reg_wr_in && (reg_addr_in == 8'h03 || reg_addr_in == 8'h07
                 || reg_addr_in == 8'h0E)) begin
      if (reg_addr_in == 8'h03) span_r <= reg_wdata_in[0];
      if (reg_addr_in == 8'h07) test_r <= reg_wdata_in[0];
      if (reg_addr_in == 8'h0E) run_r <= reg_wdata_in[0];
      stay_r <= 8'h00;
    end else if (!settled) begin
      stay_r <= stay_r + 8'h01;
    end
  end
  glyph_read_seven_a: assert property (reg_rd_in && reg_addr_in == 8'h05
    |=> !reg_rdata_out[7]) else $error("glyph read with bit 7 set");
  pair_exclusive_a: assert property (pair_sel_out != 2'b11)
    else $error("both digit pairs driven");
  row_shape_a: assert property ($onehot0(row_out) || row_out == 7'h7F)
    else $error("row drive neither one-hot nor all");
  two_digit_span_a: assert property (settled && !test_r && !span_r
    |-> !pair_sel_out[1]) else $error("digits 2 and 3 scanned with short span");
  test_all_rows_a: assert property (settled && test_r
    |-> row_out == 7'h00 || row_out == 7'h7F) else $error("test mode row not all on");
  test_all_cols_a: assert property (settled && test_r && row_out != 7'h00
    |-> col_out == 10'h3FF) else $error("test mode columns not all on");
  run_off_dark_a: assert property ((settled && !test_r && !run_r)[*2]
    |-> row_out == 7'h00) else $error("rows lit while display disabled");
  reset_state_a: assert property ($fell(srst_in) |-> blink_phase_out
    && pair_sel_out == 2'b00 && row_out == 7'h00) else $error("bad state after reset");
endmodule
bind lgs_top lgs_top_chk u_chk (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .pair_sel_out(pair_sel_out),
  .row_out(row_out), .col_out(col_out), .blink_phase_out(blink_phase_out));

/* lgs_top_bench.sv */
// self-checking bench for the glyph scan block
`timescale 1ns/10ps
`include "lgs_defines.vh"
module lgs_top_bench;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic osc_pin;
  logic [1:0] pair_sel_out;
  logic [6:0] row_out;
  logic [9:0] col_out;
  logic blink_phase_out;
  logic [7:0] rd_val;
  logic [7:0] glyph [5] = '{8'h42, 8'h61, 8'h51, 8'h49, 8'h46};
  int err_count = 0;
  int tests_run = 0;
  int osc_edges = 0;
  int n_edges;
  localparam int ROWT = 32;
  localparam int BLNK = 8;
  // rising edges of the multiplex clock pin
  always @(posedge osc_pin) osc_edges++;
  // 250 MHz system clock
  always #2 sys_clk_in = ~sys_clk_in;
  lgs_osc_model u_osc (.multiplex_clock_pin_out(osc_pin));
  lgs_top #(.ROW_TICKS(ROWT), .BLINK_HALF(BLNK)) dut (.sys_clk_in(sys_clk_in),
    .srst_in(srst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .multiplex_clock_pin_in(osc_pin), .pair_sel_out(pair_sel_out), .row_out(row_out),
    .col_out(col_out), .blink_phase_out(blink_phase_out));
  // verdict and end of run
  task automatic finish_test();
    if (err_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  // one-cycle register read, data taken in the following cycle
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    rd_val = reg_rdata_out;
  endtask
  // value compare
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait for a given pair slot and row drive
  task automatic wait_scan(input logic [1:0] ps, input logic [6:0] rw);
    int n = 0;
    #1;
    while (!(pair_sel_out === ps && row_out === rw) && n < 20000) begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
    if (n == 20000) begin
      err_count++;
      finish_test();
    end
  endtask
  // pin edges while the watched output stays high: lit rows or blink phase
  task automatic high_edges(input bit use_row, output int n);
    int start;
    int k;
    bit lvl;
    start = 0;
    @(posedge sys_clk_in);
    #1;
    for (int s = 0; s < 3; s++) begin
      k = 0;
      lvl = (s == 1);
      while (((use_row ? (|row_out) : blink_phase_out) !== lvl) && k < 2000) begin
        @(posedge sys_clk_in);
        #1;
        k++;
      end
      if (k == 2000) begin
        err_count++;
        finish_test();
      end
      if (s == 1) begin
        start = osc_edges;
      end
    end
    n = osc_edges - start;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    wr(`LGS_ADDR_CTRL, 8'h01);
    wr(`LGS_ADDR_GLYPH_PORT, 8'h8A);
    for (int i = 0; i < 5; i++) begin
      wr(`LGS_ADDR_GLYPH_PORT, glyph[i]);
    end
    wr(`LGS_ADDR_GLYPH_PORT, 8'h15);
    wr(`LGS_ADDR_GLYPH_PORT, 8'h8A);
    for (int i = 0; i < 5; i++) begin
      rd(`LGS_ADDR_GLYPH_PORT);
      chk({8'h00, rd_val}, {8'h00, glyph[i]});
    end
    rd(`LGS_ADDR_GLYPH_PORT);
    chk({8'h00, rd_val}, 16'h0015);
    // last entry wraps to the first
    wr(`LGS_ADDR_GLYPH_PORT, 8'h80);
    wr(`LGS_ADDR_GLYPH_PORT, 8'h11);
    wr(`LGS_ADDR_GLYPH_PORT, 8'hF7);
    wr(`LGS_ADDR_GLYPH_PORT, 8'h33);
    rd(`LGS_ADDR_GLYPH_PORT);
    chk({8'h00, rd_val}, 16'h0011);
    wr(`LGS_ADDR_GLYPH_PORT, 8'hF7);
    rd(`LGS_ADDR_GLYPH_PORT);
    chk({8'h00, rd_val}, 16'h0033);
    rd(`LGS_ADDR_GLYPH_PORT);
    chk({8'h00, rd_val}, 16'h0011);
    // out-of-range pointer loads land on the first entry
    for (int v = 248; v < 256; v++) begin
      wr(`LGS_ADDR_GLYPH_PORT, v[7:0]);
      rd(`LGS_ADDR_GLYPH_PORT);
      chk({8'h00, rd_val}, 16'h0011);
    end
    rd(8'h10);
    chk({8'h00, rd_val}, 16'h0000);
    // digit 0 shows user glyph two, two-digit span
    wr(`LGS_ADDR_DIGIT0, 8'h02);
    wr(`LGS_ADDR_SCAN_SPAN, 8'hFE);
    wait_scan(2'b01, 7'h01);
    chk({6'h00, col_out}, 16'h000E);
    wr(`LGS_ADDR_SCAN_SPAN, 8'h01);
    wait_scan(2'b10, 7'h01);
    chk({6'h00, col_out}, 16'h0000);
    // display test lights every column in both pair slots
    wr(`LGS_ADDR_DISP_TEST, 8'h01);
    wait_scan(2'b01, 7'h7F);
    chk({6'h00, col_out}, 16'h03FF);
    wait_scan(2'b10, 7'h7F);
    chk({6'h00, col_out}, 16'h03FF);
    high_edges(1'b1, n_edges);
    chk(16'(n_edges), 16'(`LGS_DUTY_TEST * ROWT / `LGS_DUTY_STEPS));
    wr(`LGS_ADDR_DISP_TEST, 8'h00);
    wait_scan(2'b01, 7'h01);
    chk({6'h00, col_out}, 16'h000E);
    high_edges(1'b1, n_edges);
    chk(16'(n_edges), 16'(`LGS_DUTY_NORMAL * ROWT / `LGS_DUTY_STEPS));
    rd(`LGS_ADDR_DIGIT0);
    chk({8'h00, rd_val}, 16'h0002);
    // middle column cleared while the glyph is on show
    wr(`LGS_ADDR_GLYPH_PORT, 8'h8C);
    wr(`LGS_ADDR_GLYPH_PORT, 8'h00);
    repeat (4) @(posedge sys_clk_in);
    wait_scan(2'b01, 7'h01);
    chk({6'h00, col_out}, 16'h000A);
    // blink half period in pin edges, fast rate then slow rate
    high_edges(1'b0, n_edges);
    chk(16'(n_edges), 16'(BLNK));
    wr(`LGS_ADDR_CTRL, 8'h03);
    high_edges(1'b0, n_edges);
    chk(16'(n_edges), 16'(2 * BLNK));
    // display disabled: pair selects and rows dark
    wr(`LGS_ADDR_CTRL, 8'h00);
    repeat (300) @(posedge sys_clk_in);
    #1;
    chk({7'h00, pair_sel_out, row_out}, 16'h0000);
    finish_test();
  end
endmodule
